// file: verilog/dtc_pkg.sv
package dtc_pkg;

  // Register addresses
  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0LO = 8'h8a;
  localparam logic [7:0] DTC_ADDR_T1LO = 8'h8b;
  localparam logic [7:0] DTC_ADDR_T0HI = 8'h8c;
  localparam logic [7:0] DTC_ADDR_T1HI = 8'h8d;
  // Bit addresses 0x88..0x8f hit the control register
  localparam logic [4:0] DTC_BIT_BASE = 5'h11;
  localparam logic [7:0] DTC_RESET_BYTE = 8'h00;

  // Prescaler divide counts, minus one
  localparam logic [5:0] DTC_DIV12_LAST = 6'h0b;
  localparam logic [5:0] DTC_DIV4_LAST = 6'h03;
  localparam logic [5:0] DTC_DIV48_LAST = 6'h2f;
  localparam logic [2:0] DTC_EXT_DIV_LAST = 3'h7;

  typedef enum logic [1:0] {
    DTC_MODE13,
    DTC_MODE16,
    DTC_MODE8R,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  typedef enum logic [1:0] {
    DTC_PRE_DIV12,
    DTC_PRE_DIV4,
    DTC_PRE_DIV48,
    DTC_PRE_EXT8
  } dtc_pre_t;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq1_flag;
    logic ext_irq1_type;
    logic ext_irq0_flag;
    logic ext_irq0_type;
  } dtc_ctrl_t;

  typedef struct packed {
    logic timer1_gate_ctl;
    logic timer1_count_select;
    dtc_mode_t timer1_mode_field;
    logic timer0_gate_ctl;
    logic timer0_count_select;
    dtc_mode_t timer0_mode_field;
  } dtc_modesel_t;

  // Special function register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } dtc_sfr_req_t;

  // Vectoring acknowledges, one-cycle pulses
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic ext_irq1;
    logic ext_irq0;
  } dtc_ack_t;

  // Settings held in neighbouring registers
  typedef struct packed {
    logic ext_irq1_polarity;
    logic ext_irq0_polarity;
    logic timer1_sysclk;
    logic timer0_sysclk;
    dtc_pre_t prescale_select;
  } dtc_cfg_t;

endpackage

// file: verilog/dtc_pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with edge pulses taken from the second stage
module dtc_pin_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Asynchronous pin
  input wire logic pin,
  // Synchronised level and edges
  output logic level,
  output logic fall,
  output logic rise
);
  import dtc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } dtc_sync_t;

  dtc_sync_t cur;
  dtc_sync_t next_cur;

  // First stage feeds only the second
  always_comb
  begin
    next_cur = cur;
    next_cur.s1 = pin;
    next_cur.s2 = cur.s1;
    next_cur.prev = cur.s2;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cur <= {INIT, INIT, INIT};
    else
      cur <= next_cur;
  end

  // Edges compare settled stages, so one edge gives one pulse
  assign level = cur.s2;
  assign fall = cur.prev & ~cur.s2;
  assign rise = ~cur.prev & cur.s2;

  property p_one_fall;
    @(posedge core_clk) disable iff (!rst_b)
    fall |=> !fall;
  endproperty
  a_one_fall: assert property (p_one_fall)
    else $error("falling edge pulse lasted two cycles");

endmodule

// file: verilog/dtc_timer_ctrl.sv
`timescale 1ns/1ns
module dtc_timer_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register access and vectoring
  input wire dtc_pkg::dtc_sfr_req_t sfr,
  input wire dtc_pkg::dtc_ack_t ack,
  input wire dtc_pkg::dtc_cfg_t cfg,
  output logic [7:0] sfr_rd_data,
  // Pins
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic ext_irq0_input,
  input wire logic ext_irq1_input,
  input wire logic ext_clk_pin,
  // Requests to the interrupt controller, and the timer 1 overflow pulse
  output logic timer0_irq_req,
  output logic timer1_irq_req,
  output logic ext_irq0_req,
  output logic ext_irq1_req,
  output logic timer1_ovf_pulse
);
  import dtc_pkg::*;

  typedef struct packed {
    dtc_ctrl_t ctrl;
    dtc_modesel_t mode;
    logic [7:0] t0lo;
    logic [7:0] t0hi;
    logic [7:0] t1lo;
    logic [7:0] t1hi;
    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    logic irq0_prev;
    logic irq1_prev;
    logic t1_ovf;
    logic [7:0] rd_data;
  } dtc_state_t;

  dtc_state_t cur;
  dtc_state_t next_cur;

  logic t0_pin_fall;
  logic t1_pin_fall;
  logic irq0_lvl;
  logic irq1_lvl;
  logic ext_rise;
  logic pre_tick;
  logic [5:0] pre_last;
  logic irq0_act;
  logic irq1_act;
  logic split;
  logic t0_clk;
  logic t0_tick;
  logic t1_tick;
  logic t0_en;
  logic t1_en;
  logic t0_ovf;
  logic t0hi_ovf;
  logic t1_ovf;
  logic [16:0] t0_step;
  logic [16:0] t1_step;
  logic ctrl_bit_wr;

  // One counting step: {overflow, high, low}
  function automatic logic [16:0] dtc_count(input dtc_mode_t m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [12:0] v13;
    logic [16:0] v16;
    logic [16:0] r;
    v13 = {hi, lo[4:0]} + 13'h1;
    v16 = {1'b0, hi, lo} + 17'h1;
    r = {1'b0, hi, lo};
    case (m)
      DTC_MODE13: r = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
      DTC_MODE16: r = v16;
      DTC_MODE8R: r = {&lo, hi, (&lo) ? hi : lo + 8'h1};
      DTC_MODE_SPLIT: r = {&lo, hi, lo + 8'h1};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // Pin synchronisers; count pins idle high, irq inputs idle high
  dtc_pin_sync #(.INIT(1'b1)) u_sync_t0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(timer0_count_pin),
    .level(),
    .fall(t0_pin_fall),
    .rise()
  );
  dtc_pin_sync #(.INIT(1'b1)) u_sync_t1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(timer1_count_pin),
    .level(),
    .fall(t1_pin_fall),
    .rise()
  );
  dtc_pin_sync #(.INIT(1'b1)) u_sync_irq0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ext_irq0_input),
    .level(irq0_lvl),
    .fall(),
    .rise()
  );
  dtc_pin_sync #(.INIT(1'b1)) u_sync_irq1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ext_irq1_input),
    .level(irq1_lvl),
    .fall(),
    .rise()
  );
  dtc_pin_sync #(.INIT(1'b0)) u_sync_ext (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ext_clk_pin),
    .level(),
    .fall(),
    .rise(ext_rise)
  );

  // Prescaler tick; compare with >= so a select change cannot stall it
  always_comb
  begin
    case (cfg.prescale_select)
      DTC_PRE_DIV12: pre_last = DTC_DIV12_LAST;
      DTC_PRE_DIV4: pre_last = DTC_DIV4_LAST;
      DTC_PRE_DIV48: pre_last = DTC_DIV48_LAST;
      default: pre_last = DTC_DIV12_LAST;
    endcase
    if (cfg.prescale_select == DTC_PRE_EXT8)
      pre_tick = ext_rise && (cur.ext_cnt == DTC_EXT_DIV_LAST);
    else
      pre_tick = (cur.pre_cnt >= pre_last);
  end

  // Gating and clock choice for both timers
  always_comb
  begin
    split = (cur.mode.timer0_mode_field == DTC_MODE_SPLIT);
    irq0_act = cfg.ext_irq0_polarity ? irq0_lvl : ~irq0_lvl;
    irq1_act = cfg.ext_irq1_polarity ? irq1_lvl : ~irq1_lvl;
    t0_clk = cfg.timer0_sysclk | pre_tick;
    t0_tick = cur.mode.timer0_count_select ? t0_pin_fall : t0_clk;
    // Split mode takes the pin away from timer 1
    if (cur.mode.timer1_count_select && !split)
      t1_tick = t1_pin_fall;
    else
      t1_tick = cfg.timer1_sysclk | pre_tick;
    t0_en = cur.ctrl.timer0_run &&
            (!cur.mode.timer0_gate_ctl || irq0_act);
    // With timer 0 split, timer 1 runs on its mode and gate, without its run bit
    t1_en = (cur.mode.timer1_mode_field != DTC_MODE_SPLIT) &&
            (split || cur.ctrl.timer1_run) &&
            (!cur.mode.timer1_gate_ctl || irq1_act);
    t0_step = dtc_count(cur.mode.timer0_mode_field, cur.t0hi, cur.t0lo);
    t1_step = dtc_count(cur.mode.timer1_mode_field, cur.t1hi, cur.t1lo);
    t0_ovf = t0_en && t0_tick && t0_step[16];
    t0hi_ovf = split && cur.ctrl.timer1_run && t0_clk && (&cur.t0hi);
    t1_ovf = t1_en && t1_tick && t1_step[16];
    ctrl_bit_wr = sfr.bit_wr && (sfr.addr[7:3] == DTC_BIT_BASE);
  end

  // Next state: counting, then software writes, then flag sets
  always_comb
  begin
    next_cur = cur;
    next_cur.t1_ovf = t1_ovf;
    // Prescale counters
    if (pre_tick || cfg.prescale_select == DTC_PRE_EXT8)
      next_cur.pre_cnt = '0;
    else
      next_cur.pre_cnt = cur.pre_cnt + 6'h1;
    if (ext_rise)
      next_cur.ext_cnt = cur.ext_cnt + 3'h1;
    // Timer 0, all four modes through one step function
    if (t0_en && t0_tick)
    begin
      next_cur.t0hi = t0_step[15:8];
      next_cur.t0lo = t0_step[7:0];
    end
    // Split mode high byte on the internal clock
    if (split && cur.ctrl.timer1_run && t0_clk)
      next_cur.t0hi = cur.t0hi + 8'h1;
    if (t1_en && t1_tick)
    begin
      next_cur.t1hi = t1_step[15:8];
      next_cur.t1lo = t1_step[7:0];
    end
    // Byte writes win over a count in the same cycle
    if (sfr.wr)
    begin
      case (sfr.addr)
        DTC_ADDR_CTRL: next_cur.ctrl = dtc_ctrl_t'(sfr.wdata);
        DTC_ADDR_MODE: next_cur.mode = dtc_modesel_t'(sfr.wdata);
        DTC_ADDR_T0LO: next_cur.t0lo = sfr.wdata;
        DTC_ADDR_T1LO: next_cur.t1lo = sfr.wdata;
        DTC_ADDR_T0HI: next_cur.t0hi = sfr.wdata;
        DTC_ADDR_T1HI: next_cur.t1hi = sfr.wdata;
        default: next_cur.ctrl = next_cur.ctrl;
      endcase
    end
    // Single-bit writes into the control register
    if (ctrl_bit_wr)
      next_cur.ctrl[sfr.addr[2:0]] = sfr.bit_val;
    // Vectoring clears; edge-mode only for the irq flags
    if (ack.timer1)
      next_cur.ctrl.timer1_overflow_flag = 1'b0;
    if (ack.timer0)
      next_cur.ctrl.timer0_overflow_flag = 1'b0;
    if (ack.ext_irq1 && cur.ctrl.ext_irq1_type)
      next_cur.ctrl.ext_irq1_flag = 1'b0;
    if (ack.ext_irq0 && cur.ctrl.ext_irq0_type)
      next_cur.ctrl.ext_irq0_flag = 1'b0;
    // Hardware sets win over any clear in the same cycle
    if (t0_ovf)
      next_cur.ctrl.timer0_overflow_flag = 1'b1;
    if (t0hi_ovf || (t1_ovf && !split))
      next_cur.ctrl.timer1_overflow_flag = 1'b1;
    next_cur.irq0_prev = irq0_act;
    next_cur.irq1_prev = irq1_act;
    if (cur.ctrl.ext_irq1_type ? (irq1_act && !cur.irq1_prev) : irq1_act)
      next_cur.ctrl.ext_irq1_flag = 1'b1;
    if (cur.ctrl.ext_irq0_type ? (irq0_act && !cur.irq0_prev) : irq0_act)
      next_cur.ctrl.ext_irq0_flag = 1'b1;
    // Read data captured on the read strobe; unmapped reads zero
    if (sfr.rd)
    begin
      case (sfr.addr)
        DTC_ADDR_CTRL: next_cur.rd_data = cur.ctrl;
        DTC_ADDR_MODE: next_cur.rd_data = cur.mode;
        DTC_ADDR_T0LO: next_cur.rd_data = cur.t0lo;
        DTC_ADDR_T1LO: next_cur.rd_data = cur.t1lo;
        DTC_ADDR_T0HI: next_cur.rd_data = cur.t0hi;
        DTC_ADDR_T1HI: next_cur.rd_data = cur.t1hi;
        default: next_cur.rd_data = DTC_RESET_BYTE;
      endcase
    end
  end

  // Everything clears at reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign sfr_rd_data = cur.rd_data;
  assign timer0_irq_req = cur.ctrl.timer0_overflow_flag;
  assign timer1_irq_req = cur.ctrl.timer1_overflow_flag;
  assign ext_irq0_req = cur.ctrl.ext_irq0_flag;
  assign ext_irq1_req = cur.ctrl.ext_irq1_flag;
  assign timer1_ovf_pulse = cur.t1_ovf;

  // Overflow of timer 0 raises its flag next cycle
  property p_t0_flag;
    @(posedge core_clk) disable iff (!rst_b)
    t0_ovf |=> cur.ctrl.timer0_overflow_flag;
  endproperty
  a_t0_flag: assert property (p_t0_flag)
    else $error("timer 0 overflow did not set its flag");

  property p_t1_flag;
    @(posedge core_clk) disable iff (!rst_b)
    (t0hi_ovf || (t1_ovf && !split)) |=> cur.ctrl.timer1_overflow_flag;
  endproperty
  a_t1_flag: assert property (p_t1_flag)
    else $error("timer 1 overflow did not set its flag");

  property p_t1_stopped;
    @(posedge core_clk) disable iff (!rst_b)
    (!cur.ctrl.timer1_run && !split && !sfr.wr) |=>
      $stable({cur.t1hi, cur.t1lo});
  endproperty
  a_t1_stopped: assert property (p_t1_stopped)
    else $error("timer 1 counted with run bit clear");

  property p_t0_gated;
    @(posedge core_clk) disable iff (!rst_b)
    (cur.mode.timer0_gate_ctl && !irq0_act && !split && !sfr.wr) |=>
      $stable({cur.t0hi, cur.t0lo});
  endproperty
  a_t0_gated: assert property (p_t0_gated)
    else $error("timer 0 counted while gate input inactive");

  property p_reload;
    @(posedge core_clk) disable iff (!rst_b)
    (t0_ovf && cur.mode.timer0_mode_field == DTC_MODE8R && !sfr.wr) |=>
      (cur.t0lo == $past(cur.t0hi)) && $stable(cur.t0hi);
  endproperty
  a_reload: assert property (p_reload)
    else $error("8-bit reload did not load low byte from high byte");

  property p_wrap13;
    @(posedge core_clk) disable iff (!rst_b)
    (t0_en && t0_tick && cur.mode.timer0_mode_field == DTC_MODE13 &&
     (&{cur.t0hi, cur.t0lo[4:0]}) && !sfr.wr) |=>
      (cur.t0hi == 8'h00) && (cur.t0lo[4:0] == 5'h00) &&
      cur.ctrl.timer0_overflow_flag;
  endproperty
  a_wrap13: assert property (p_wrap13)
    else $error("13-bit wrap wrong");

  property p_low_write;
    @(posedge core_clk) disable iff (!rst_b)
    (sfr.wr && sfr.addr == DTC_ADDR_T0LO) |=> cur.t0lo == $past(sfr.wdata);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("timer 0 low byte write lost");

  property p_edge_irq0;
    @(posedge core_clk) disable iff (!rst_b)
    (cur.ctrl.ext_irq0_type && irq0_act && !cur.irq0_prev) |=>
      cur.ctrl.ext_irq0_flag;
  endproperty
  a_edge_irq0: assert property (p_edge_irq0)
    else $error("interrupt 0 edge did not set its flag");

  property p_level_irq1;
    @(posedge core_clk) disable iff (!rst_b)
    (!cur.ctrl.ext_irq1_type && irq1_act) |=> cur.ctrl.ext_irq1_flag;
  endproperty
  a_level_irq1: assert property (p_level_irq1)
    else $error("interrupt 1 level did not set its flag");

endmodule

// file: bench/dtc_core_model.sv
`timescale 1ns/1ns
// Processor core side of the register bus and of vectoring
module dtc_core_model (
  // Clock
  input wire logic core_clk,
  // Requests to the block
  output dtc_pkg::dtc_sfr_req_t sfr,
  output dtc_pkg::dtc_ack_t ack,
  // Read return
  input wire logic [7:0] sfr_rd_data
);
  import dtc_pkg::*;

  // Bus idle at time zero
  initial
  begin
    sfr = '0;
    ack = '0;
  end

  // One request for one edge; k is {rd, bit_wr, wr}
  task automatic put(input logic [2:0] k, input logic [7:0] a,
    input logic [7:0] d);
    @(negedge core_clk);
    sfr.wr = k[0];
    sfr.bit_wr = k[1];
    sfr.rd = k[2];
    sfr.addr = a;
    sfr.wdata = d;
    sfr.bit_val = d[0];
    @(negedge core_clk);
    // Strobes drop and address and data show the inverse, so stale values never match
    sfr.wr = 1'b0;
    sfr.bit_wr = 1'b0;
    sfr.rd = 1'b0;
    sfr.addr = ~a;
    sfr.wdata = ~d;
    sfr.bit_val = ~d[0];
  endtask

  // Vectoring pulse, one cycle
  task automatic pulse(input logic [3:0] which);
    @(negedge core_clk);
    ack = which;
    @(negedge core_clk);
    ack = '0;
  endtask
endmodule

// file: bench/test_dtc_timer_ctrl.sv
`timescale 1ns/1ns
module test_dtc_timer_ctrl;
  import dtc_pkg::*;
  logic core_clk;
  logic rst_b;
  dtc_sfr_req_t sfr;
  dtc_ack_t ack;
  dtc_cfg_t cfg;
  logic [7:0] sfr_rd_data;
  logic t0_pin;
  logic t1_pin;
  logic t1_pulse;
  int pulses;
  int p0;
  logic [1:0] irq_in;
  logic [3:0] reqs;
  logic [7:0] v;
  int fails;
  int tests_run;
  // Mode, low byte, high byte, expected high byte after the wrap
  localparam logic [31:0] MT [3] = '{32'h01ff_ff00, 32'h001f_ff00,
    32'h02ff_8080};

  dtc_core_model dtc_core_model_i (
    .core_clk(core_clk),
    .sfr(sfr),
    .ack(ack),
    .sfr_rd_data(sfr_rd_data)
  );

  dtc_timer_ctrl dtc_timer_ctrl_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sfr(sfr),
    .ack(ack),
    .cfg(cfg),
    .sfr_rd_data(sfr_rd_data),
    .timer0_count_pin(t0_pin),
    .timer1_count_pin(t1_pin),
    .ext_irq0_input(irq_in[0]),
    .ext_irq1_input(irq_in[1]),
    .ext_clk_pin(1'b0),
    .timer0_irq_req(reqs[2]),
    .timer1_irq_req(reqs[3]),
    .ext_irq0_req(reqs[0]),
    .ext_irq1_req(reqs[1]),
    .timer1_ovf_pulse(t1_pulse)
  );

  // Overflow pulses of timer 1, counted so a scenario can take a difference
  always @(posedge core_clk)
  begin
    if (t1_pulse === 1'b1)
      pulses <= pulses + 1;
  end

  // 10 MHz
  always #50 core_clk = ~core_clk;

  task automatic end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dtc_core_model_i.put(3'b001, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    dtc_core_model_i.put(3'b100, a, 8'h00);
    @(negedge core_clk);
    d = sfr_rd_data;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("read %h", a), e, d);
  endtask

  // Bounded wait on a request line; a hang shows up as a mismatch
  task automatic wait_req(input int k);
    int n;
    n = 0;
    while (reqs[k] !== 1'b1 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    chk($sformatf("request %0d", k), 8'h01, {7'h0, reqs[k]});
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    cfg = '{1'b0, 1'b0, 1'b1, 1'b1, DTC_PRE_DIV12};
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    pulses = 0;
    irq_in = 2'b11;
    fails = 0;
    tests_run = 0;
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    // Reset values, byte and bit access, refused places
    rchk(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_MODE, 8'h00);
    rchk(DTC_ADDR_T0LO, 8'h00);
    wr(DTC_ADDR_CTRL, 8'haa);
    rchk(DTC_ADDR_CTRL, 8'haa);
    wr(DTC_ADDR_T0LO, 8'h5a);
    rchk(DTC_ADDR_T0LO, 8'h5a);
    wr(DTC_ADDR_CTRL, 8'h00);
    dtc_core_model_i.put(3'b010, 8'h8e, 8'h01);
    dtc_core_model_i.put(3'b010, 8'h96, 8'h01);
    rchk(DTC_ADDR_CTRL, 8'h40);
    dtc_core_model_i.put(3'b010, 8'h8e, 8'h00);
    rchk(DTC_ADDR_CTRL, 8'h00);
    rchk(8'h90, 8'h00);
    // Timer 0 wraps in 16-bit, 13-bit and reload modes
    for (int i = 0; i < 3; i++)
    begin
      wr(DTC_ADDR_MODE, MT[i][31:24]);
      wr(DTC_ADDR_T0LO, MT[i][23:16]);
      wr(DTC_ADDR_T0HI, MT[i][15:8]);
      wr(DTC_ADDR_CTRL, 8'h10);
      wait_req(2);
      dtc_core_model_i.pulse(4'h4);
      rchk(DTC_ADDR_CTRL, 8'h10);
      wr(DTC_ADDR_CTRL, 8'h00);
      rchk(DTC_ADDR_T0HI, MT[i][7:0]);
      rd(DTC_ADDR_T0LO, v);
      chk("low msb", {7'h0, MT[i][7]}, {7'h0, v[7]});
    end
    // Timer 1 in 16-bit mode, then inactive mode
    wr(DTC_ADDR_MODE, 8'h10);
    wr(DTC_ADDR_T1LO, 8'hff);
    wr(DTC_ADDR_T1HI, 8'hff);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_req(3);
    dtc_core_model_i.pulse(4'h8);
    rchk(DTC_ADDR_CTRL, 8'h40);
    wr(DTC_ADDR_MODE, 8'h30);
    wr(DTC_ADDR_T1LO, 8'hff);
    repeat (10) @(negedge core_clk);
    wr(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_T1LO, 8'hff);
    // Split mode: high byte runs on the timer 1 run bit
    wr(DTC_ADDR_MODE, 8'h03);
    wr(DTC_ADDR_T0HI, 8'hff);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_req(3);
    wr(DTC_ADDR_CTRL, 8'h00);
    // Gate held shut by an inactive input, then opened
    wr(DTC_ADDR_MODE, 8'h09);
    wr(DTC_ADDR_T0LO, 8'h00);
    wr(DTC_ADDR_T0HI, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h10);
    repeat (20) @(negedge core_clk);
    wr(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_T0LO, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h10);
    irq_in[0] = 1'b0;
    repeat (20) @(negedge core_clk);
    irq_in[0] = 1'b1;
    repeat (4) @(negedge core_clk);
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_T0LO, v);
    chk("gated count", 8'h01, {7'h0, v != 8'h00});
    // Pin counting: three falling edges, three counts
    wr(DTC_ADDR_MODE, 8'h05);
    wr(DTC_ADDR_T0LO, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h10);
    repeat (3)
    begin
      t0_pin = 1'b0;
      repeat (4) @(negedge core_clk);
      t0_pin = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    wr(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_T0LO, 8'h03);
    // External interrupts, edge then level, active low
    wr(DTC_ADDR_MODE, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(DTC_ADDR_CTRL, 8'(1 << (2 * k)));
      irq_in[k] = 1'b0;
      wait_req(k);
      dtc_core_model_i.pulse(4'(1 << k));
      rchk(DTC_ADDR_CTRL, 8'(1 << (2 * k)));
      wr(DTC_ADDR_CTRL, 8'h00);
      dtc_core_model_i.pulse(4'(1 << k));
      rchk(DTC_ADDR_CTRL, 8'(2 << (2 * k)));
      irq_in[k] = 1'b1;
      repeat (4) @(negedge core_clk);
      wr(DTC_ADDR_CTRL, 8'h00);
      rchk(DTC_ADDR_CTRL, 8'h00);
    end
    // Timer 1 on its count pin: wrap on the first edge, one more count
    wr(DTC_ADDR_MODE, 8'h50);
    wr(DTC_ADDR_T1LO, 8'hff);
    wr(DTC_ADDR_T1HI, 8'hff);
    p0 = pulses;
    wr(DTC_ADDR_CTRL, 8'h40);
    repeat (2)
    begin
      t1_pin = 1'b0;
      repeat (4) @(negedge core_clk);
      t1_pin = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    wait_req(3);
    chk("overflow pulses", 8'h01, 8'(pulses - p0));
    wr(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_T1LO, 8'h01);
    // Timer 1 gate held shut by an inactive interrupt 1 input
    wr(DTC_ADDR_MODE, 8'h90);
    wr(DTC_ADDR_CTRL, 8'h40);
    repeat (20) @(negedge core_clk);
    wr(DTC_ADDR_CTRL, 8'h00);
    rchk(DTC_ADDR_T1LO, 8'h01);
    // Prescaled clock: the run window spans 42 counting edges
    cfg.timer0_sysclk = 1'b0;
    wr(DTC_ADDR_MODE, 8'h01);
    for (int s = 0; s < 2; s++)
    begin
      cfg.prescale_select = s ? DTC_PRE_DIV12 : DTC_PRE_DIV4;
      wr(DTC_ADDR_T0LO, 8'h00);
      wr(DTC_ADDR_CTRL, 8'h10);
      repeat (40) @(negedge core_clk);
      wr(DTC_ADDR_CTRL, 8'h00);
      rd(DTC_ADDR_T0LO, v);
      chk("prescaled count", 8'h01,
        {7'h0, (v == (s ? 8'h03 : 8'h0a)) || (v == (s ? 8'h04 : 8'h0b))});
    end
    end_of_test();
  end
endmodule
